// *** hdl/ssbp_host.sv ***
// Host end: issues reads and writes with late write data
`timescale 1ns/1ps
`default_nettype none
module ssbp_host
(
    input  wire logic                             mclk,        // Bus clock
    input  wire logic                             arst_n,      // Async reset
    input  wire logic                             req_valid,   // Command strobe
    input  wire logic                             req_write,   // 1 write, 0 read
    input  wire logic                             req_burst,   // Advance burst instead of new address
    input  wire logic [ssbp_pkg::ADDR_W-1:0]      req_addr,    // Word address
    input  wire logic [ssbp_pkg::LANES-1:0]       req_lanes,   // Lanes to write
    input  wire logic [ssbp_pkg::DATA_W-1:0]      req_wdata,   // Write data
    input  wire logic                             cfg_flow,    // Flow-through mode
    input  wire logic                             cfg_interleave, // Interleaved burst order
    input  wire logic                             cfg_sleep,   // Sleep request
    output logic [ssbp_pkg::DATA_W-1:0]           rsp_data,    // Read data
    output logic                                  rsp_valid,   // Read data strobe
    ssbp_if.host                                  bus          // Memory bus
);
    localparam int DW = ssbp_pkg::DATA_W;

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    ssbp_pkg::ssbp_cmd_t cmd_ff, nxt_cmd;
    logic [ssbp_pkg::ADDR_W-1:0] a_ff, nxt_a;
    logic [ssbp_pkg::LANES-1:0]  l_ff, nxt_l;
    logic [DW-1:0] wd_ff [ssbp_pkg::LAT_PIPE+1];
    logic [ssbp_pkg::LAT_PIPE:0] wv_ff;
    logic [ssbp_pkg::LAT_PIPE:0] rv_ff;
    logic          wr_burst_ff, nxt_wr_burst;
    logic [DW-1:0] rd_ff;
    logic          rdv_ff;
    logic          is_wr;

    always_comb
    begin
        nxt_cmd      = ssbp_pkg::SSBP_IDLE;
        nxt_a        = a_ff;
        nxt_l        = l_ff;
        nxt_wr_burst = wr_burst_ff;
        if (req_valid && !cfg_sleep)
        begin
            nxt_a = req_addr;
            nxt_l = req_write ? req_lanes : '0;
            if (req_burst)
                nxt_cmd = ssbp_pkg::SSBP_BURST;
            else
            begin
                nxt_cmd      = req_write ? ssbp_pkg::SSBP_WRITE : ssbp_pkg::SSBP_READ;
                nxt_wr_burst = req_write;
            end
        end
    end

    assign is_wr = (nxt_cmd == ssbp_pkg::SSBP_WRITE)
                   || (nxt_cmd == ssbp_pkg::SSBP_BURST && wr_burst_ff);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_ff      <= ssbp_pkg::SSBP_IDLE;
            a_ff        <= '0;
            l_ff        <= '0;
            wr_burst_ff <= 1'b0;
            wv_ff       <= '0;
            rv_ff       <= '0;
            rd_ff       <= '0;
            rdv_ff      <= 1'b0;
            for (int i = 0; i <= ssbp_pkg::LAT_PIPE; i++)
                wd_ff[i] <= '0;
        end
        else
        begin
            cmd_ff      <= nxt_cmd;
            a_ff        <= nxt_a;
            l_ff        <= nxt_l;
            wr_burst_ff <= nxt_wr_burst;
            // Write data trails its command by the mode's latency
            wd_ff[0]    <= req_wdata;
            wd_ff[1]    <= wd_ff[0];
            wd_ff[2]    <= wd_ff[1];
            wv_ff       <= {wv_ff[ssbp_pkg::LAT_PIPE-1:0], is_wr};
            rv_ff       <= {rv_ff[ssbp_pkg::LAT_PIPE-1:0],
                            (nxt_cmd != ssbp_pkg::SSBP_IDLE) && !is_wr};
            rd_ff       <= bus.dq_ram_o;
            rdv_ff      <= cfg_flow ? rv_ff[ssbp_pkg::LAT_FLOW] : rv_ff[ssbp_pkg::LAT_PIPE];
        end
    end

    // ------------------------------------------------------------
    // Bus pins: command, address, lanes and data from rising-edge flops; sleep and mode pins follow cfg inputs, scan tied
    // ------------------------------------------------------------
    assign bus.addr                     = a_ff;
    assign bus.write_n                  = !(cmd_ff == ssbp_pkg::SSBP_WRITE);
    assign bus.burst_step               = (cmd_ff == ssbp_pkg::SSBP_BURST);
    assign bus.lane_write_enables_n     = ~l_ff;
    assign bus.chip_select_low_first_n  = (cmd_ff == ssbp_pkg::SSBP_IDLE);
    assign bus.chip_select_high         = (cmd_ff != ssbp_pkg::SSBP_IDLE);
    assign bus.chip_select_low_second_n = (cmd_ff == ssbp_pkg::SSBP_IDLE);
    // Output enable only while read data is due
    assign bus.out_enable_n             = !(cfg_flow ? rv_ff[ssbp_pkg::LAT_FLOW] : rv_ff[ssbp_pkg::LAT_PIPE]);
    assign bus.sleep_request            = cfg_sleep;
    assign bus.flow_through_select_n    = !cfg_flow;
    assign bus.burst_order_select       = cfg_interleave;
    assign bus.dq_host_o  = cfg_flow ? wd_ff[ssbp_pkg::LAT_FLOW] : wd_ff[ssbp_pkg::LAT_PIPE];
    assign bus.dq_host_oe = cfg_flow ? wv_ff[ssbp_pkg::LAT_FLOW]
                                     : wv_ff[ssbp_pkg::LAT_PIPE];
    assign bus.tck = 1'b0;
    assign bus.tms = 1'b1;
    assign bus.tdi = 1'b0;

    assign rsp_data  = rd_ff;
    assign rsp_valid = rdv_ff;
endmodule
`default_nettype wire

// *** hdl/ssbp_if.sv ***
// Bus between host and synchronous SRAM
`timescale 1ns/1ps
`default_nettype none
interface ssbp_if;
    logic [ssbp_pkg::ADDR_W-1:0] addr;
    logic                        write_n;
    logic                        burst_step;
    logic [ssbp_pkg::LANES-1:0]  lane_write_enables_n;
    logic                        chip_select_low_first_n;
    logic                        chip_select_high;
    logic                        chip_select_low_second_n;
    logic                        out_enable_n;
    logic                        sleep_request;
    logic                        flow_through_select_n;
    logic                        burst_order_select;
    logic [ssbp_pkg::DATA_W-1:0] dq_host_o;
    logic                        dq_host_oe;
    logic [ssbp_pkg::DATA_W-1:0] dq_ram_o;
    logic                        dq_ram_oe;
    logic                        tck;
    logic                        tms;
    logic                        tdi;
    logic                        tdo;
    logic                        tdo_oe;
    modport ram
    (
        input  addr, write_n, burst_step, lane_write_enables_n, chip_select_low_first_n,
        input  chip_select_high, chip_select_low_second_n, out_enable_n, sleep_request,
        input  flow_through_select_n, burst_order_select, dq_host_o, dq_host_oe, tck, tms, tdi,
        output dq_ram_o, dq_ram_oe, tdo, tdo_oe
    );
    modport host
    (
        output addr, write_n, burst_step, lane_write_enables_n, chip_select_low_first_n,
        output chip_select_high, chip_select_low_second_n, out_enable_n, sleep_request,
        output flow_through_select_n, burst_order_select, dq_host_o, dq_host_oe, tck, tms, tdi,
        input  dq_ram_o, dq_ram_oe, tdo, tdo_oe
    );
endinterface
`default_nettype wire

// *** hdl/ssbp_pkg.sv ***
// Shared constants and types for the synchronous SRAM bus port
package ssbp_pkg;
    localparam int ADDR_W     = 10;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int BURST_W    = 2;
    localparam int LAT_PIPE   = 2;
    localparam int LAT_FLOW   = 1;
    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    typedef enum logic [1:0]
    {
        SSBP_IDLE  = 2'b00,
        SSBP_READ  = 2'b01,
        SSBP_WRITE = 2'b10,
        SSBP_BURST = 2'b11
    } ssbp_cmd_t;
endpackage

// *** hdl/ssbp_ram.sv ***
// RAM end: synchronous SRAM with late write, bursts, sleep and scan port
`timescale 1ns/1ps
`default_nettype none
module ssbp_ram
#(
    parameter int DEPTH = 1 << ssbp_pkg::ADDR_W
)
(
    input  wire logic mclk,       // Bus clock
    input  wire logic arst_n,     // Async reset
    ssbp_if.ram       bus         // Memory bus
);
    localparam int AW = ssbp_pkg::ADDR_W;
    localparam int BW = ssbp_pkg::BURST_W;
    localparam int DW = ssbp_pkg::DATA_W;
    localparam int LN = ssbp_pkg::LANES;
    localparam int LW = ssbp_pkg::LANE_W;

    logic [DW-1:0] rd_word;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic sel;
    logic take;
    assign sel  = !bus.chip_select_low_first_n && bus.chip_select_high
                  && !bus.chip_select_low_second_n;
    assign take = !bus.sleep_request;
    logic          flow;
    assign flow = !bus.flow_through_select_n;

    // Burst state
    logic [AW-1:0] base_ff,  nxt_base;
    logic [BW-1:0] start_ff, nxt_start;
    logic [BW-1:0] cnt_ff,   nxt_cnt;
    logic          wr_ff,    nxt_wr;
    logic          act_ff,   nxt_act;
    logic [LN-1:0] be_ff,    nxt_be;
    // Addressed word of this cycle
    logic [AW-1:0] cur_addr;
    logic          cur_valid;
    logic          cur_wr;
    logic [LN-1:0] cur_be;
    logic [BW-1:0] seq;

    always_comb
    begin
        nxt_base  = base_ff;
        nxt_start = start_ff;
        nxt_cnt   = cnt_ff;
        nxt_wr    = wr_ff;
        nxt_act   = act_ff;
        nxt_be    = be_ff;
        cur_valid = 1'b0;
        cur_wr    = 1'b0;
        cur_be    = '0;
        seq       = '0;
        cur_addr  = bus.addr;
        if (take)
        begin
            if (bus.burst_step)
            begin
                if (act_ff)
                begin
                    nxt_cnt = cnt_ff + ssbp_pkg::BURST_ONE;
                    if (bus.burst_order_select)
                        seq = start_ff ^ nxt_cnt;
                    else
                        seq = start_ff + nxt_cnt;
                    cur_addr  = {base_ff[AW-1:BW], seq};
                    cur_valid = 1'b1;
                    cur_wr    = wr_ff;
                    cur_be    = wr_ff ? ~bus.lane_write_enables_n : '0;
                    nxt_be = cur_be;
                end
            end
            else if (sel)
            begin
                nxt_base  = bus.addr;
                nxt_start = bus.addr[BW-1:0];
                nxt_cnt   = '0;
                nxt_wr    = !bus.write_n;
                nxt_act   = 1'b1;
                nxt_be    = ~bus.lane_write_enables_n;
                cur_valid = 1'b1;
                cur_wr    = !bus.write_n;
                cur_be    = ~bus.lane_write_enables_n;
            end
            else
                nxt_act = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            base_ff  <= '0;
            start_ff <= '0;
            cnt_ff   <= '0;
            wr_ff    <= 1'b0;
            act_ff   <= 1'b0;
            be_ff    <= '0;
        end
        else
        begin
            base_ff  <= nxt_base;
            start_ff <= nxt_start;
            cnt_ff   <= nxt_cnt;
            wr_ff    <= nxt_wr;
            act_ff   <= nxt_act;
            be_ff    <= nxt_be;
        end
    end

    // ------------------------------------------------------------
    // Late-write and read pipelines
    // ------------------------------------------------------------
    logic [AW-1:0] wa_ff [2];
    logic [LN-1:0] wb_ff [2];
    logic [1:0]    wv_ff;
    logic [AW-1:0] ra_ff,  nxt_ra;
    logic          rv_ff,  nxt_rv;
    logic [DW-1:0] q_ff,   nxt_q;
    logic          qv_ff,  nxt_qv;
    logic [AW-1:0] nxt_wa0;
    logic [LN-1:0] nxt_wb0;
    logic          nxt_wv0;

    always_comb
    begin
        nxt_wa0 = cur_addr;
        nxt_wb0 = cur_be;
        nxt_wv0 = cur_valid && cur_wr;
        nxt_ra  = cur_addr;
        nxt_rv  = cur_valid && !cur_wr;
        nxt_q   = rd_word;
        nxt_qv  = rv_ff;
    end

    // Write data lands one edge late in flow, two in pipeline
    logic          wdo;
    logic [AW-1:0] wdo_a;
    logic [LN-1:0] wdo_b;
    assign wdo   = flow ? wv_ff[0] : wv_ff[1];
    assign wdo_a = flow ? wa_ff[0] : wa_ff[1];
    assign wdo_b = flow ? wb_ff[0] : wb_ff[1];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wa_ff[0] <= '0;
            wa_ff[1] <= '0;
            wb_ff[0] <= '0;
            wb_ff[1] <= '0;
            wv_ff    <= '0;
            ra_ff    <= '0;
            rv_ff    <= 1'b0;
            q_ff     <= '0;
            qv_ff    <= 1'b0;
        end
        else
        begin
            wa_ff[0] <= nxt_wa0;
            wa_ff[1] <= wa_ff[0];
            wb_ff[0] <= nxt_wb0;
            wb_ff[1] <= wb_ff[0];
            wv_ff    <= {wv_ff[0], nxt_wv0};
            ra_ff    <= nxt_ra;
            rv_ff    <= nxt_rv;
            q_ff     <= nxt_q;
            qv_ff    <= nxt_qv;
        end
    end

    // Self-timed lane writes; a late write still in flight is forwarded to a read of its word
    for (genvar g = 0; g < LN; g++)
    begin : g_lane
        logic [LW-1:0] lane_mem [DEPTH];
        always_ff @(posedge mclk)
        begin
            if (wdo && wdo_b[g] && bus.dq_host_oe)
                lane_mem[wdo_a] <= bus.dq_host_o[g*LW +: LW];
        end
        assign rd_word[g*LW +: LW] = (wdo && wdo_b[g] && bus.dq_host_oe && wdo_a == ra_ff)
                                     ? bus.dq_host_o[g*LW +: LW] : lane_mem[ra_ff];
    end

    // ------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------
    // Flow path is combinational from the address register, pipe path registered
    assign bus.dq_ram_o  = flow ? rd_word : q_ff;
    assign bus.dq_ram_oe = !bus.out_enable_n && (flow ? rv_ff : qv_ff);

    // ------------------------------------------------------------
    // Boundary scan: bypass-only access port
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SSBP_TAP_IDLE  = 2'b00,
        SSBP_TAP_SHIFT = 2'b01,
        SSBP_TAP_EXIT  = 2'b10
    } ssbp_tap_t;
    ssbp_tap_t tap_ff, nxt_tap;
    logic      byp_ff, nxt_byp;
    logic      tck_d_ff;
    logic      rise;
    assign rise = bus.tck && !tck_d_ff;

    always_comb
    begin
        nxt_tap = tap_ff;
        nxt_byp = byp_ff;
        if (rise)
        begin
            case (tap_ff)
                SSBP_TAP_IDLE:  nxt_tap = bus.tms ? SSBP_TAP_IDLE : SSBP_TAP_SHIFT;
                SSBP_TAP_SHIFT:
                begin
                    nxt_byp = bus.tdi;
                    nxt_tap = bus.tms ? SSBP_TAP_EXIT : SSBP_TAP_SHIFT;
                end
                SSBP_TAP_EXIT:  nxt_tap = bus.tms ? SSBP_TAP_IDLE : SSBP_TAP_SHIFT;
                default:        nxt_tap = SSBP_TAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tap_ff   <= SSBP_TAP_IDLE;
            byp_ff   <= 1'b0;
            tck_d_ff <= 1'b0;
        end
        else
        begin
            tap_ff   <= nxt_tap;
            byp_ff   <= nxt_byp;
            tck_d_ff <= bus.tck;
        end
    end

    assign bus.tdo    = byp_ff;
    assign bus.tdo_oe = (tap_ff == SSBP_TAP_SHIFT);
endmodule
`default_nettype wire

// *** tb/ssbp_properties.sv ***
// Concurrent checks on the bus between host and RAM ends
`timescale 1ns/1ps
`default_nettype none
module ssbp_properties
(
    input wire logic mclk,                     // Bus clock
    input wire logic arst_n,                   // Async reset
    input wire logic write_n,                  // Low means write
    input wire logic burst_step,               // Burst advance
    input wire logic chip_select_low_first_n,  // Enable, low active
    input wire logic chip_select_high,         // Enable, high active
    input wire logic chip_select_low_second_n, // Enable, low active
    input wire logic out_enable_n,             // Output enable
    input wire logic sleep_request,            // Sleep
    input wire logic flow_through_select_n,    // Low means flow-through
    input wire logic burst_order_select,       // Burst order
    input wire logic dq_host_oe,               // Host drives data
    input wire logic dq_ram_oe                 // RAM drives data
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic cs_all;
    logic rd_cmd;
    logic wr_cmd;
    logic rd_cause;
    assign cs_all   = !chip_select_low_first_n && chip_select_high && !chip_select_low_second_n;
    assign rd_cmd   = cs_all && write_n && !burst_step && !sleep_request;
    assign wr_cmd   = cs_all && !write_n && !burst_step && !sleep_request;
    assign rd_cause = !sleep_request && (burst_step || (cs_all && write_n));
    property p_oe_off;
        out_enable_n |-> !dq_ram_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("RAM drives data with output enable off");
    property p_flow_read;
        rd_cmd && !flow_through_select_n |=> out_enable_n || dq_ram_oe;
    endproperty
    a_flow_read: assert property (p_flow_read) else $error("Flow-through read data late");
    property p_pipe_read;
        rd_cmd && flow_through_select_n |-> ##2 (out_enable_n || dq_ram_oe);
    endproperty
    a_pipe_read: assert property (p_pipe_read) else $error("Pipelined read data not two edges on");
    property p_flow_cause;
        dq_ram_oe && !$past(flow_through_select_n) |-> $past(rd_cause);
    endproperty
    a_flow_cause: assert property (p_flow_cause) else $error("Flow read data without a taken read");
    property p_pipe_cause;
        dq_ram_oe && $past(flow_through_select_n, 2) |-> $past(rd_cause, 2);
    endproperty
    a_pipe_cause: assert property (p_pipe_cause) else $error("Pipelined data without a taken read");
    property p_flow_wr;
        wr_cmd && !flow_through_select_n |=> dq_host_oe;
    endproperty
    a_flow_wr: assert property (p_flow_wr) else $error("Write data not one edge late");
    property p_pipe_wr;
        wr_cmd && flow_through_select_n |-> ##2 dq_host_oe;
    endproperty
    a_pipe_wr: assert property (p_pipe_wr) else $error("Write data not two edges late");
    property p_no_clash;
        !(dq_host_oe && dq_ram_oe);
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("Both ends drive data");
    property p_select;
        (chip_select_high == !chip_select_low_first_n) && (chip_select_low_first_n == chip_select_low_second_n);
    endproperty
    a_select: assert property (p_select) else $error("Enables not driven as one select");
    property p_order_static;
        burst_step |-> $stable(burst_order_select);
    endproperty
    a_order_static: assert property (p_order_static) else $error("Burst order moved in a burst");
endmodule
`default_nettype wire

// *** tb/test_sync_sram_bus_port.sv ***
// Self-checking bench joining host and RAM ends
`timescale 1ns/1ps
`default_nettype none
module test_sync_sram_bus_port;
    logic                        mclk;
    logic                        arst_n;
    logic                        req_valid;
    logic                        req_write;
    logic                        req_burst;
    logic [ssbp_pkg::ADDR_W-1:0] req_addr;
    logic [ssbp_pkg::LANES-1:0]  req_lanes;
    logic [ssbp_pkg::DATA_W-1:0] req_wdata;
    logic                        cfg_flow;
    logic                        cfg_interleave;
    logic                        cfg_sleep;
    logic [ssbp_pkg::DATA_W-1:0] rsp_data;
    logic                        rsp_valid;
    logic [ssbp_pkg::DATA_W-1:0] rq[$];
    int                          err_total;
    int                          check_count;

    ssbp_if ssbp_if_inst ();
    ssbp_ram ssbp_ram_inst (.mclk(mclk), .arst_n(arst_n), .bus(ssbp_if_inst.ram));
    ssbp_host ssbp_host_inst
    (
        .mclk(mclk), .arst_n(arst_n), .req_valid(req_valid), .req_write(req_write),
        .req_burst(req_burst), .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .cfg_flow(cfg_flow), .cfg_interleave(cfg_interleave), .cfg_sleep(cfg_sleep),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .bus(ssbp_if_inst.host)
    );
    ssbp_properties ssbp_properties_inst
    (
        .mclk(mclk), .arst_n(arst_n), .write_n(ssbp_if_inst.write_n), .burst_step(ssbp_if_inst.burst_step),
        .chip_select_low_first_n(ssbp_if_inst.chip_select_low_first_n),
        .chip_select_high(ssbp_if_inst.chip_select_high),
        .chip_select_low_second_n(ssbp_if_inst.chip_select_low_second_n),
        .out_enable_n(ssbp_if_inst.out_enable_n), .sleep_request(ssbp_if_inst.sleep_request),
        .flow_through_select_n(ssbp_if_inst.flow_through_select_n),
        .burst_order_select(ssbp_if_inst.burst_order_select),
        .dq_host_oe(ssbp_if_inst.dq_host_oe), .dq_ram_oe(ssbp_if_inst.dq_ram_oe)
    );

    always #4 mclk = ~mclk;
    always @(negedge mclk)
        if (rsp_valid === 1'b1)
            rq.push_back(rsp_data);

    task automatic close_out;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [ssbp_pkg::DATA_W-1:0] got, input logic [ssbp_pkg::DATA_W-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [ssbp_pkg::DATA_W-1:0] pat(input logic [ssbp_pkg::ADDR_W-1:0] a, input logic [3:0] s);
        return {s, 8'hC3, 14'h2A5B, a};
    endfunction

    function automatic logic [ssbp_pkg::DATA_W-1:0] merge(input logic [ssbp_pkg::DATA_W-1:0] o,
        input logic [ssbp_pkg::DATA_W-1:0] n, input logic [ssbp_pkg::LANES-1:0] ln);
        logic [ssbp_pkg::DATA_W-1:0] r;
        r = o;
        for (int g = 0; g < ssbp_pkg::LANES; g++)
            if (ln[g])
                r[g*ssbp_pkg::LANE_W +: ssbp_pkg::LANE_W] = n[g*ssbp_pkg::LANE_W +: ssbp_pkg::LANE_W];
        return r;
    endfunction

    task automatic req(input logic w, input logic b, input logic [ssbp_pkg::ADDR_W-1:0] a,
        input logic [ssbp_pkg::LANES-1:0] ln, input logic [ssbp_pkg::DATA_W-1:0] d);
        req_valid = 1'b1;
        req_write = w;
        req_burst = b;
        req_addr  = a;
        req_lanes = ln;
        req_wdata = d;
        @(negedge mclk);
    endtask

    task automatic idle(input int n);
        req_valid = 1'b0;
        req_burst = 1'b0;
        repeat (n) @(negedge mclk);
    endtask

    task automatic get_rsp(input logic [ssbp_pkg::DATA_W-1:0] exp);
        int n;
        n = 0;
        while (rq.size() == 0 && n < 20)
        begin
            @(negedge mclk);
            n++;
        end
        if (rq.size() == 0)
        begin
            err_total++;
            $display("MISMATCH at %0t: read answer missing", $time);
            close_out();
        end
        else
            chk(rq.pop_front(), exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_mix(input logic flow);
        logic [ssbp_pkg::ADDR_W-1:0] b;
        b = flow ? 10'h040 : 10'h020;
        cfg_flow = flow;
        idle(4);
        req(1'b1, 1'b0, b, 4'hF, pat(b, 4'h1));
        req(1'b1, 1'b0, b + 10'h001, 4'hF, pat(b + 10'h001, 4'h2));
        req(1'b0, 1'b0, b, 4'h0, '0);
        req(1'b1, 1'b0, b + 10'h002, 4'hF, pat(b + 10'h002, 4'h3));
        req(1'b0, 1'b0, b + 10'h001, 4'h0, '0);
        req(1'b0, 1'b0, b + 10'h002, 4'h0, '0);
        idle(1);
        get_rsp(pat(b, 4'h1));
        get_rsp(pat(b + 10'h001, 4'h2));
        get_rsp(pat(b + 10'h002, 4'h3));
    endtask

    task automatic sc_lanes;
        req(1'b1, 1'b0, 10'h080, 4'hF, pat(10'h080, 4'h4));
        req(1'b1, 1'b0, 10'h080, 4'h5, pat(10'h3FF, 4'hE));
        req(1'b0, 1'b0, 10'h080, 4'h0, '0);
        req(1'b1, 1'b0, 10'h080, 4'hA, pat(10'h155, 4'h7));
        req(1'b0, 1'b0, 10'h080, 4'h0, '0);
        idle(1);
        get_rsp(merge(pat(10'h080, 4'h4), pat(10'h3FF, 4'hE), 4'h5));
        get_rsp(merge(merge(pat(10'h080, 4'h4), pat(10'h3FF, 4'hE), 4'h5), pat(10'h155, 4'h7), 4'hA));
    endtask

    task automatic sc_burst(input logic inter);
        logic [ssbp_pkg::ADDR_W-1:0] b;
        b = inter ? 10'h0C8 : 10'h0C4;
        cfg_interleave = inter;
        idle(4);
        for (int i = 0; i < 4; i++)
            req(1'b1, 1'b0, b + 10'(i), 4'hF, pat(b + 10'(i), 4'h9));
        req(1'b0, 1'b0, b + 10'h001, 4'h0, '0);
        for (int k = 1; k < 4; k++)
            req(1'b0, 1'b1, b, 4'h0, '0);
        idle(1);
        for (int k = 0; k < 4; k++)
            get_rsp(pat(b + 10'(inter ? (1 ^ k) : ((1 + k) & 3)), 4'h9));
    endtask

    task automatic sc_sleep;
        cfg_sleep = 1'b1;
        idle(3);
        req(1'b1, 1'b0, 10'h020, 4'hF, pat(10'h020, 4'hB));
        req(1'b0, 1'b0, 10'h020, 4'h0, '0);
        idle(10);
        chk(ssbp_pkg::DATA_W'(rq.size()), '0);
        cfg_sleep = 1'b0;
        idle(3);
        // Write reaches the bus while the RAM sleeps
        req(1'b1, 1'b0, 10'h020, 4'hF, pat(10'h020, 4'hC));
        cfg_sleep = 1'b1;
        idle(4);
        cfg_sleep = 1'b0;
        idle(3);
        req(1'b0, 1'b0, 10'h020, 4'h0, '0);
        idle(1);
        get_rsp(pat(10'h020, 4'h1));
    endtask

    initial
    begin
        mclk           = 1'b0;
        arst_n         = 1'b0;
        req_valid      = 1'b0;
        req_write      = 1'b0;
        req_burst      = 1'b0;
        req_addr       = '0;
        req_lanes      = '0;
        req_wdata      = '0;
        cfg_flow       = 1'b0;
        cfg_interleave = 1'b0;
        cfg_sleep      = 1'b0;
        err_total      = 0;
        check_count    = 0;
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        sc_mix(1'b0);
        sc_lanes();
        sc_burst(1'b0);
        sc_burst(1'b1);
        sc_mix(1'b1);
        sc_lanes();
        sc_sleep();
        idle(4);
        close_out();
    end
endmodule
`default_nettype wire
